// ### edp_par_chk.sv
// Purpose: Transmit-side parity checker for one stream beat.
// Assumes: Purely combinational; qualification by handshake is done here.
// Notes:   Reports one flag per cycle however many lanes are wrong.
`timescale 1ns/100ps
module edp_par_chk
(
	// Beat in
	input  wire logic [edp_pkg::DATA_W-1:0] data,
	input  wire logic [edp_pkg::LANES-1:0]  keep,
	input  wire logic [edp_pkg::LANES-1:0]  parity,
	input  wire logic                       xfer,
	// Result
	output wire logic                       err
);

	wire logic [edp_pkg::LANES-1:0] lane_bad;
	wire logic [edp_pkg::LANES-1:0] lane_chk;

	assign lane_bad = edp_pkg::lane_parity(data) ^ parity;
	assign lane_chk = keep & {edp_pkg::LANES{xfer}};
	assign err      = |(lane_bad & lane_chk);

endmodule

// ### edp_par_gen.sv
// Purpose: Receive-side parity generator for one stream beat.
// Assumes: Purely combinational; caller decides when lanes are valid.
// Notes:   Parity is produced for every lane; receivers ignore unkept lanes.
`timescale 1ns/100ps
module edp_par_gen
(
	// Beat in
	input  wire logic [edp_pkg::DATA_W-1:0] data,
	// Parity out
	output wire logic [edp_pkg::LANES-1:0]  parity
);

	assign parity = edp_pkg::lane_parity(data);

endmodule

// ### edp_pkg.sv
// Purpose: Shared constants, types and helpers for the datapath parity block.
// Assumes: 64-bit stream datapath with eight byte lanes.
// Notes:   All register offsets are byte addresses on a 32-bit APB.
package edp_pkg;

	// ****************************************************************
	// Datapath geometry
	// ****************************************************************
	localparam int DATA_W = 64;
	localparam int LANES  = DATA_W / 8;

	typedef struct packed {
		logic [DATA_W-1:0] tdata;
		logic [LANES-1:0]  tkeep;
		logic              tlast;
		logic              tuser;
	} edp_beat_t;

	// ****************************************************************
	// Register map
	// ****************************************************************
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_CLEAR  = 8'h08;
	localparam logic [7:0] OFS_ENABLE = 8'h0C;
	localparam logic [7:0] OFS_PCOUNT = 8'h10;

	localparam int CTRL_FCS_INS = 0;
	localparam int CTRL_PRESP   = 1;
	localparam int EV_PARITY    = 0;
	localparam int EV_FCS       = 1;
	localparam int EV_W         = 2;

	localparam logic [1:0]  CTRL_RST   = 2'h0;
	localparam logic [1:0]  ENABLE_RST = 2'h0;
	localparam logic [31:0] PCOUNT_MAX = 32'hFFFFFFFF;

	// ****************************************************************
	// Helpers
	// ****************************************************************
	// Even parity bit for each byte lane: data ones plus parity is even.
	function automatic logic [LANES-1:0] lane_parity(input logic [DATA_W-1:0] d);
		logic [LANES-1:0] p;
		p = '0;
		for (int i = 0; i < LANES; i++)
		begin
			p[i] = ^d[i*8 +: 8];
		end
		return p;
	endfunction

endpackage

// ### edp_top.sv
// Purpose: Byte-wise even parity on the stream path between user logic and MAC.
// Assumes: One clock; user and MAC streams are both synchronous to clk.
// Notes:   Stream data passes straight through; statistics come from flops.
//
// The APB interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/100ps
module edp_top
(
	// Clock and reset
	input  wire logic                       clk,
	input  wire logic                       rst_b,
	// APB slave
	input  wire logic                       psel,
	input  wire logic                       penable,
	input  wire logic                       pwrite,
	input  wire logic [7:0]                 paddr,
	input  wire logic [31:0]                pwdata,
	output logic      [31:0]                prdata,
	output logic                            pready,
	output logic                            pslverr,
	// Transmit stream from user logic
	input  wire edp_pkg::edp_beat_t         tx_user_beat,
	input  wire logic [edp_pkg::LANES-1:0]  tx_user_parity,
	input  wire logic                       tx_user_tvalid,
	output logic                            tx_user_tready,
	// Transmit stream to MAC
	output edp_pkg::edp_beat_t              tx_mac_beat,
	output logic                            tx_mac_tvalid,
	input  wire logic                       tx_mac_tready,
	input  wire logic                       tx_mac_fcs_err,
	// Receive stream from MAC
	input  wire edp_pkg::edp_beat_t         rx_mac_beat,
	input  wire logic                       rx_mac_tvalid,
	// Receive stream to user logic
	output edp_pkg::edp_beat_t              rx_user_beat,
	output logic [edp_pkg::LANES-1:0]       rx_user_parity,
	output logic                            rx_user_tvalid,
	// Statistics and interrupt
	output logic                            stat_tx_bad_parity,
	output logic                            stat_tx_bad_fcs,
	output logic                            irq
);

	// ****************************************************************
	// Register state
	// ****************************************************************
	logic [1:0]              ctrl_ff;
	logic [edp_pkg::EV_W-1:0] status_ff;
	logic [edp_pkg::EV_W-1:0] enable_ff;
	logic [31:0]             pcount_ff;
	logic [31:0]             prdata_ff;
	logic                    pready_ff;
	logic                    pslverr_ff;
	logic                    irq_ff;
	logic                    pkt_err_ff;
	logic                    bad_par_ff;
	logic                    bad_fcs_ff;

	// ****************************************************************
	// Transmit path
	// ****************************************************************
	// The ready path is left combinational so the stream keeps full rate
	// with no extra buffering between user logic and the MAC.
	wire logic tx_xfer;
	wire logic tx_err_now;
	wire logic fcs_ins;
	wire logic par_resp;
	wire logic par_to_fcs;
	wire logic pkt_err_any;
	wire logic fcs_from_par;

	assign tx_xfer        = tx_user_tvalid & tx_mac_tready;
	assign tx_user_tready = tx_mac_tready;
	assign tx_mac_tvalid  = tx_user_tvalid;
	assign fcs_ins        = ctrl_ff[edp_pkg::CTRL_FCS_INS];
	assign par_resp       = ctrl_ff[edp_pkg::CTRL_PRESP];
	assign par_to_fcs     = fcs_ins & par_resp;
	assign pkt_err_any    = pkt_err_ff | tx_err_now;
	assign fcs_from_par   = par_to_fcs & tx_xfer & tx_user_beat.tlast & pkt_err_any;

	// Stomping the frame through tuser makes the MAC corrupt the inserted FCS.
	always_comb
	begin
		tx_mac_beat       = tx_user_beat;
		tx_mac_beat.tuser = tx_user_beat.tuser | fcs_from_par;
	end

	edp_par_chk u_chk
	(
		.data   (tx_user_beat.tdata),
		.keep   (tx_user_beat.tkeep),
		.parity (tx_user_parity),
		.xfer   (tx_xfer),
		.err    (tx_err_now)
	);

	wire logic nxt_pkt_err;
	wire logic nxt_bad_fcs;

	assign nxt_pkt_err = (tx_xfer & tx_user_beat.tlast) ? 1'b0
	                   : (pkt_err_ff | tx_err_now);
	assign nxt_bad_fcs = tx_mac_fcs_err | fcs_from_par;

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			pkt_err_ff <= 1'b0;
		end
		else
		begin
			pkt_err_ff <= nxt_pkt_err;
		end
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			bad_par_ff <= 1'b0;
		end
		else
		begin
			bad_par_ff <= tx_err_now;
		end
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			bad_fcs_ff <= 1'b0;
		end
		else
		begin
			bad_fcs_ff <= nxt_bad_fcs;
		end
	end

	assign stat_tx_bad_parity = bad_par_ff;
	assign stat_tx_bad_fcs    = bad_fcs_ff;

	// ****************************************************************
	// Receive path
	// ****************************************************************
	// Parity is produced on every beat; lanes with keep low carry
	// meaningless parity that the user side must disregard.
	assign rx_user_beat   = rx_mac_beat;
	assign rx_user_tvalid = rx_mac_tvalid;

	edp_par_gen u_gen
	(
		.data   (rx_mac_beat.tdata),
		.parity (rx_user_parity)
	);

	// ****************************************************************
	// APB decode
	// ****************************************************************
	wire logic apb_acc;
	wire logic apb_wr;
	wire logic apb_rd;
	wire logic hit_ctrl;
	wire logic hit_status;
	wire logic hit_clear;
	wire logic hit_enable;
	wire logic hit_pcount;
	wire logic hit_any;

	assign apb_acc    = psel & penable & ~pready_ff;
	assign apb_wr     = apb_acc & pwrite;
	assign apb_rd     = apb_acc & ~pwrite;
	assign hit_ctrl   = paddr == edp_pkg::OFS_CTRL;
	assign hit_status = paddr == edp_pkg::OFS_STATUS;
	assign hit_clear  = paddr == edp_pkg::OFS_CLEAR;
	assign hit_enable = paddr == edp_pkg::OFS_ENABLE;
	assign hit_pcount = paddr == edp_pkg::OFS_PCOUNT;
	assign hit_any    = hit_ctrl | hit_status | hit_clear | hit_enable | hit_pcount;

	wire logic [31:0] rd_mux;

	assign rd_mux = hit_ctrl   ? {30'h0, ctrl_ff}
	              : hit_status ? {30'h0, status_ff}
	              : hit_enable ? {30'h0, enable_ff}
	              : hit_pcount ? pcount_ff
	              : 32'h0;

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff  <= 32'h0;
		end
		else
		begin
			pready_ff  <= apb_acc;
			pslverr_ff <= apb_acc & ~hit_any;
			prdata_ff  <= apb_rd ? rd_mux : 32'h0;
		end
	end

	assign pready  = pready_ff;
	assign pslverr = pslverr_ff;
	assign prdata  = prdata_ff;

	// ****************************************************************
	// Control, status and interrupt
	// ****************************************************************
	wire logic [1:0]              nxt_ctrl;
	wire logic [edp_pkg::EV_W-1:0] nxt_enable;
	wire logic [edp_pkg::EV_W-1:0] ev_set;
	wire logic [edp_pkg::EV_W-1:0] ev_clr;
	wire logic [edp_pkg::EV_W-1:0] nxt_status;
	wire logic [31:0]             nxt_pcount;

	assign nxt_ctrl   = (apb_wr & hit_ctrl) ? pwdata[1:0] : ctrl_ff;
	assign nxt_enable = (apb_wr & hit_enable) ? pwdata[edp_pkg::EV_W-1:0] : enable_ff;
	assign ev_set     = {bad_fcs_ff, bad_par_ff};
	assign ev_clr     = (apb_wr & hit_clear) ? pwdata[edp_pkg::EV_W-1:0] : '0;
	// A new event in the clearing cycle survives the clear.
	assign nxt_status = (status_ff & ~ev_clr) | ev_set;
	// The counter saturates rather than wrap so a stale read never looks clean.
	assign nxt_pcount = (bad_par_ff & (pcount_ff != edp_pkg::PCOUNT_MAX))
	                  ? pcount_ff + 32'h1 : pcount_ff;

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			ctrl_ff <= edp_pkg::CTRL_RST;
		end
		else
		begin
			ctrl_ff <= nxt_ctrl;
		end
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			enable_ff <= edp_pkg::ENABLE_RST;
		end
		else
		begin
			enable_ff <= nxt_enable;
		end
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			status_ff <= '0;
		end
		else
		begin
			status_ff <= nxt_status;
		end
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			pcount_ff <= 32'h0;
		end
		else
		begin
			pcount_ff <= nxt_pcount;
		end
	end

	// Built from the next values so the line rises with the status bit itself.
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			irq_ff <= 1'b0;
		end
		else
		begin
			irq_ff <= |(nxt_status & nxt_enable);
		end
	end

	assign irq = irq_ff;

endmodule

// ### edp_top_asserts.sv
// Purpose: Port-level temporal checks for the datapath parity block.
// Assumes: One clock domain; rst_b is asynchronous and active low.
// Notes:   Bound to every edp_top instance after the module.
`timescale 1ns/100ps
module edp_top_asserts
(
	// Clock and reset
	input wire logic               clk,
	input wire logic               rst_b,
	// Register bus
	input wire logic               psel,
	input wire logic               penable,
	input wire logic               pready,
	input wire logic               pslverr,
	// Streams and statistics
	input wire edp_pkg::edp_beat_t tx_user_beat,
	input wire logic [7:0]         tx_user_parity,
	input wire logic               tx_user_tvalid,
	input wire edp_pkg::edp_beat_t tx_mac_beat,
	input wire logic               tx_mac_tready,
	input wire logic               tx_mac_fcs_err,
	input wire edp_pkg::edp_beat_t rx_mac_beat,
	input wire logic [7:0]         rx_user_parity,
	input wire logic               stat_tx_bad_parity,
	input wire logic               stat_tx_bad_fcs
);
	// ****************************************************************
	// Helper logic and properties
	// ****************************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	logic [7:0] lane_bad, rx_exp;
	logic       xfer, bad, stomp, pkt_bad_ff, nxt_pkt_bad;
	always_comb
		for (int i = 0; i < 8; i++)
		begin
			lane_bad[i] = ^tx_user_beat.tdata[i*8 +: 8] ^ tx_user_parity[i];
			rx_exp[i]   = ^rx_mac_beat.tdata[i*8 +: 8];
		end
	assign xfer        = tx_user_tvalid & tx_mac_tready;
	assign bad         = xfer & (|(lane_bad & tx_user_beat.tkeep));
	assign stomp       = xfer & tx_user_beat.tlast & tx_mac_beat.tuser & !tx_user_beat.tuser;
	// A packet remembers an earlier bad beat so that a stomp can be traced to it.
	assign nxt_pkt_bad = (xfer & tx_user_beat.tlast) ? 1'h0 : (pkt_bad_ff | bad);
	always_ff @(posedge clk or negedge rst_b)
		if (!rst_b)
			pkt_bad_ff <= 1'h0;
		else
			pkt_bad_ff <= nxt_pkt_bad;
	property p_par; bad |=> stat_tx_bad_parity; endproperty
	property p_clean; !bad |=> !stat_tx_bad_parity; endproperty
	property p_rx; 1'h1 |-> rx_user_parity == rx_exp; endproperty
	property p_fcs; tx_mac_fcs_err |=> stat_tx_bad_fcs; endproperty
	property p_cause; stat_tx_bad_fcs |-> $past(tx_mac_fcs_err | stomp); endproperty
	property p_stomp; stomp |=> stat_tx_bad_fcs; endproperty
	property p_src; stomp |-> pkt_bad_ff | bad; endproperty
	property p_wait; psel && penable && !pready |=> pready; endproperty
	property p_once; pready |=> !pready; endproperty
	a_par: assert property (p_par) else $error("bad beat not flagged");
	a_clean: assert property (p_clean) else $error("parity flag without cause");
	a_rx: assert property (p_rx) else $error("receive parity wrong");
	a_fcs: assert property (p_fcs) else $error("fcs error not flagged");
	a_cause: assert property (p_cause) else $error("bad fcs without cause");
	a_stomp: assert property (p_stomp) else $error("stomp not counted");
	a_src: assert property (p_src) else $error("stomp without parity error");
	a_wait: assert property (p_wait) else $error("bus answer late");
	a_once: assert property (p_once) else $error("bus answer too long");
	c_bad: cover property (bad);
	c_stomp: cover property (stomp);
	c_err: cover property (pready && pslverr);
endmodule
bind edp_top edp_top_asserts u_asserts (.clk, .rst_b, .psel, .penable, .pready, .pslverr,
	.tx_user_beat, .tx_user_parity, .tx_user_tvalid, .tx_mac_beat, .tx_mac_tready,
	.tx_mac_fcs_err, .rx_mac_beat, .rx_user_parity, .stat_tx_bad_parity, .stat_tx_bad_fcs);

// ### edp_user_model.sv
// Purpose: User-side stream partner: sends parity-tagged beats, audits receive parity.
// Assumes: Beat fields come from the bench; flip corrupts the chosen lanes.
// Notes:   Unkept receive lanes are never audited.
`timescale 1ns/100ps
module edp_user_model
(
	// Clock and reset
	input  wire logic               clk,
	input  wire logic               rst_b,
	// Transmit beat
	input  wire logic [63:0]        d,
	input  wire logic [7:0]         k,
	input  wire logic [7:0]         flip,
	input  wire logic               last,
	output edp_pkg::edp_beat_t      beat,
	output logic [7:0]              par,
	// Receive audit
	input  wire edp_pkg::edp_beat_t rx_beat,
	input  wire logic [7:0]         rx_par,
	input  wire logic               rx_vld,
	output logic [7:0]              rx_bad_ff
);
	// ****************************************************************
	// Even parity per lane
	// ****************************************************************
	function automatic logic [7:0] ep(input logic [63:0] v);
		for (int i = 0; i < 8; i++)
			ep[i] = ^v[i*8 +: 8];
	endfunction
	assign beat = '{tdata: d, tkeep: k, tlast: last, tuser: 1'h0};
	assign par  = ep(d) ^ flip;
	always_ff @(posedge clk or negedge rst_b)
		if (!rst_b)
			rx_bad_ff <= 8'h00;
		else if (rx_vld && ((ep(rx_beat.tdata) ^ rx_par) & rx_beat.tkeep) != 8'h00)
			rx_bad_ff <= rx_bad_ff + 8'h01;
endmodule

// ### eth_datapath_parity_tb.sv
// Purpose: Self-checking bench for the datapath parity block.
// Assumes: 100 MHz clock; the bus waits on pready rather than a fixed count.
// Notes:   Single-beat cases run from a table; multi-beat and reset cases follow.
`timescale 1ns/100ps
module eth_datapath_parity_tb;
	typedef struct packed
	{
		logic [1:0] ctrl;
		logic [7:0] keep;
		logic [7:0] flip;
		logic       rdy;
		logic       fe;
		logic       par;
		logic       fcs;
	} edp_row_t;
	logic               clk, rst_b, psel, penable, pwrite, pready, pslverr, irq, e, lst;
	logic               tx_user_tvalid, tx_user_tready, tx_mac_tvalid, tx_mac_tready;
	logic               tx_mac_fcs_err, rx_mac_tvalid, rx_user_tvalid;
	logic               stat_tx_bad_parity, stat_tx_bad_fcs;
	logic [7:0]         paddr, flp, kep, rx_bad, tx_user_parity, rx_user_parity;
	logic [31:0]        pwdata, prdata, q;
	logic [63:0]        dat;
	edp_pkg::edp_beat_t tx_user_beat, tx_mac_beat, rx_mac_beat, rx_user_beat;
	int                 fails = 0, cmp_count = 0, npar = 0;
	edp_row_t           r;
	// Hex digits: ctrl, keep, flip, then ready, fcs error, parity flag, bad-fcs flag.
	edp_row_t           rows [11] = '{22'h0FF008, 22'h0FF08A, 22'h00FF08, 22'h0FFFFA,
		22'h0FF010, 22'h1FF01A, 22'h2FF01A, 22'h3FF01B, 22'h3FF008, 22'h0FF00D, 22'h33CC38};
	logic [7:0]         ra [5] = '{edp_pkg::OFS_CTRL, edp_pkg::OFS_ENABLE, edp_pkg::OFS_STATUS,
		edp_pkg::OFS_PCOUNT, 8'h40};
	assign rx_mac_beat = '{tdata: dat, tkeep: kep, tlast: lst, tuser: 1'h0};
	always #5 clk = ~clk;
	edp_top u_dut (.clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .tx_user_beat, .tx_user_parity, .tx_user_tvalid, .tx_user_tready, .tx_mac_beat,
		.tx_mac_tvalid, .tx_mac_tready, .tx_mac_fcs_err, .rx_mac_beat, .rx_mac_tvalid,
		.rx_user_beat, .rx_user_parity, .rx_user_tvalid, .stat_tx_bad_parity, .stat_tx_bad_fcs,
		.irq);
	edp_user_model u_usr (.clk, .rst_b, .d(dat), .k(kep), .flip(flp), .last(lst),
		.beat(tx_user_beat), .par(tx_user_parity), .rx_beat(rx_user_beat),
		.rx_par(rx_user_parity), .rx_vld(rx_user_tvalid), .rx_bad_ff(rx_bad));
	// ****************************************************************
	// Tasks
	// ****************************************************************
	task results;
		if (fails == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] x);
		cmp_count++;
		if (g !== x)
		begin
			fails++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, x);
		end
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		{psel, penable, pwrite, paddr, pwdata} <= {1'h1, 1'h0, w, a, d};
		@(posedge clk);
		penable <= 1'h1;
		// The answer is taken only at a rising edge; the watchdog bounds a missing one.
		do
			@(posedge clk);
		while (pready !== 1'h1);
		q = prdata;
		e = pslverr;
		{psel, penable} <= 2'h0;
	endtask
	initial
	begin
		#100000;
		fails++;
		results();
	end
	initial
	begin
		{clk, rst_b, psel, penable, pwrite, tx_user_tvalid, tx_mac_fcs_err, rx_mac_tvalid} = '0;
		{lst, paddr, pwdata, dat, kep, flp, tx_mac_tready} = '0;
		repeat (20) @(posedge clk);
		rst_b <= 1'h1;
		for (int j = 0; j < 5; j++)
		begin
			apb(1'h0, ra[j], 32'h0);
			chk(q, 32'h0);
			chk({31'h0, e}, {31'h0, j == 4});
		end
		for (int i = 0; i < 11; i++)
		begin
			r = rows[i];
			apb(1'h1, edp_pkg::OFS_CTRL, {30'h0, r.ctrl});
			@(posedge clk);
			{dat, kep, flp, lst} <= {64'h0123456789ABCDEF + 64'(i), r.keep, r.flip, 1'h1};
			{tx_user_tvalid, rx_mac_tvalid, tx_mac_tready, tx_mac_fcs_err} <= {2'h3, r.rdy, r.fe};
			#1 chk({tx_mac_tvalid, tx_user_tready, rx_user_tvalid, tx_mac_beat.tuser},
				{1'h1, r.rdy, 1'h1, r.fcs & ~r.fe});
			chk({tx_mac_beat.tkeep, rx_user_beat.tkeep, tx_mac_beat.tdata[15:0]},
				{r.keep, r.keep, dat[15:0]});
			@(posedge clk);
			{tx_user_tvalid, rx_mac_tvalid, tx_mac_fcs_err} <= 3'h0;
			#1 chk(stat_tx_bad_parity, r.par);
			chk(stat_tx_bad_fcs, r.fcs);
			npar += r.par;
		end
		@(posedge clk);
		{tx_user_tvalid, tx_mac_tready, kep, flp, lst} <= {2'h3, 8'hFF, 8'h01, 1'h0};
		@(posedge clk);
		{flp, lst} <= {8'h00, 1'h1};
		#1 chk(stat_tx_bad_parity, 1'h1);
		chk(tx_mac_beat.tuser, 1'h1);
		chk(stat_tx_bad_fcs, 1'h0);
		@(posedge clk);
		tx_user_tvalid <= 1'h0;
		#1 chk(stat_tx_bad_fcs, 1'h1);
		chk(stat_tx_bad_parity, 1'h0);
		apb(1'h0, edp_pkg::OFS_PCOUNT, 32'h0);
		chk(q, 32'(npar + 1));
		apb(1'h0, edp_pkg::OFS_STATUS, 32'h0);
		chk(q, 32'h3);
		chk(irq, 1'h0);
		apb(1'h1, edp_pkg::OFS_ENABLE, 32'h1);
		@(posedge clk);
		#1 chk(irq, 1'h1);
		apb(1'h1, edp_pkg::OFS_CLEAR, 32'h1);
		@(posedge clk);
		#1 chk(irq, 1'h0);
		apb(1'h0, edp_pkg::OFS_STATUS, 32'h0);
		chk(q, 32'h2);
		chk(rx_bad, 8'h00);
		@(posedge clk);
		rst_b <= 1'h0;
		@(posedge clk);
		rst_b <= 1'h1;
		apb(1'h0, edp_pkg::OFS_CTRL, 32'h0);
		chk(q, 32'h0);
		apb(1'h0, edp_pkg::OFS_PCOUNT, 32'h0);
		chk(q, 32'h0);
		chk(irq, 1'h0);
		results();
	end
endmodule
